// file: rtl/homing_pkg.sv
//
// Behaviour
// - codes 1/2 limit switch neg/pos then index; 17/18 same, programmed distance
// - codes 7..10 positive reference search to index; 23..26 to distance
// - codes 11..14 negative reference search to index; 27..30 to distance
// - code 31 index pulse negative direction, code 34 positive direction
// - code 35 loads actual position with a value, no movement
// - each reference variant fixes direction inversion and inside/outside end
// - method accepts 1..35, resets to 18, new value acts immediately
// - distance methods end at offset from switching point; default 24
// - offset, home value and both limits latched when movement starts
// - on success position counter loaded with home value at reference point
// - nonzero switching point limit cancels movement with error when exceeded
// - nonzero overtravel limit: switch must reactivate within it or cancel
// - at switch stop motor, then move back (onward for non-inverting reference codes) to its switching point
// - interrupted movement leaves zero point invalid; must be restarted
// - status bit 12 is 1 only after homing completed successfully
package homing_pkg;

    // -------------------------------------------------------------------
    // parameter addresses
    // -------------------------------------------------------------------
    localparam logic [15:0] ADDR_METHOD     = 16'h1b18;
    localparam logic [15:0] ADDR_SETPOS     = 16'h1b2c;
    localparam logic [15:0] ADDR_SP_LIMIT   = 16'h280c;
    localparam logic [15:0] ADDR_OFFSET     = 16'h280e;
    localparam logic [15:0] ADDR_HOME       = 16'h2816;
    localparam logic [15:0] ADDR_OT_LIMIT   = 16'h281a;

    // -------------------------------------------------------------------
    // reset values and ranges
    // -------------------------------------------------------------------
    localparam logic [15:0] RST_METHOD      = 16'h0012;
    localparam logic [15:0] METHOD_MIN      = 16'h0001;
    localparam logic [15:0] METHOD_MAX      = 16'h0023;
    localparam logic [31:0] RST_SETPOS      = 32'h0000_0000;
    localparam logic [31:0] RST_SP_LIMIT    = 32'h0000_0000;
    localparam logic [31:0] RST_OFFSET      = 32'h0000_0018;
    localparam logic [31:0] RST_HOME        = 32'h0000_0000;
    localparam logic [31:0] RST_OT_LIMIT    = 32'h0000_0000;

    // -------------------------------------------------------------------
    // status word fields
    // -------------------------------------------------------------------
    localparam int STAT_HOMED_BIT = 12;
    localparam int STAT_ERROR_BIT = 13;

    // -------------------------------------------------------------------
    // method decoding
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {
        KIND_NONE   = 3'h0,
        KIND_LIMIT  = 3'h1,
        KIND_REF    = 3'h2,
        KIND_INDEX  = 3'h3,
        KIND_SETPOS = 3'h4
    } method_kind_t;

    typedef struct packed {
        method_kind_t kind;
        logic         search_pos;  // 1: search in positive direction
        logic         invert;      // direction reverses in switch
        logic         outside;     // end point outside switch region
        logic         use_index;   // end at index pulse, else at distance
    } method_info_t;

    typedef enum logic [7:0] {
        ST_IDLE   = 8'h01,
        ST_SEARCH = 8'h02,
        ST_HALT1  = 8'h04,
        ST_BACK   = 8'h08,
        ST_FINAL  = 8'h10,
        ST_HALT2  = 8'h20,
        ST_ABORT  = 8'h40,
        ST_FAULT  = 8'h80
    } home_state_t;

endpackage : homing_pkg

// file: rtl/homing_method_control.sv
`timescale 1ns/10ps
module homing_method_control #(
    parameter int PIN_COUNT = 4
) (
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    // parameter access
    input  wire logic [15:0] param_addr_in,
    input  wire logic [31:0] param_wdata_in,
    input  wire logic        param_wr_in,
    input  wire logic        param_rd_in,
    output logic      [31:0] param_rdata_out,
    // control word bit 4 and halt / quick stop
    input  wire logic        homing_start_in,
    input  wire logic        halt_in,
    input  wire logic        error_ack_in,
    // switch and encoder pins
    input  wire logic        negative_limit_switch_in,
    input  wire logic        positive_limit_switch_in,
    input  wire logic        reference_switch_in,
    input  wire logic        index_pulse_in,
    // motion side
    input  wire logic [31:0] position_in,
    input  wire logic        motor_standstill_in,
    output logic             move_run_out,
    output logic             move_positive_out,
    output logic             move_slow_out,
    output logic             pos_load_out,
    output logic      [31:0] pos_load_value_out,
    output logic             homing_error_out,
    output logic      [15:0] drive_status_word_out
);
    import homing_pkg::*;

    // -------------------------------------------------------------------
    // method decode
    // -------------------------------------------------------------------
    function automatic method_info_t decode(input logic [15:0] m);
        method_info_t d;
        d = '{kind: KIND_NONE, search_pos: 1'b0, invert: 1'b0,
              outside: 1'b1, use_index: 1'b1};
        case (m)
            16'h0001, 16'h0002, 16'h0011, 16'h0012: begin
                d.kind       = KIND_LIMIT;
                d.search_pos = !m[0]; // odd codes seek the negative switch
                d.use_index  = (m < 16'h0011);
            end
            16'h0007, 16'h0008, 16'h0009, 16'h000a,
            16'h0017, 16'h0018, 16'h0019, 16'h001a: begin
                d.kind       = KIND_REF;
                d.search_pos = 1'b1;
                d.use_index  = (m < 16'h0017);
            end
            16'h000b, 16'h000c, 16'h000d, 16'h000e,
            16'h001b, 16'h001c, 16'h001d, 16'h001e: begin
                d.kind       = KIND_REF;
                d.use_index  = (m < 16'h001b);
            end
            16'h001f: d.kind = KIND_INDEX;
            16'h0022: begin
                d.kind       = KIND_INDEX;
                d.search_pos = 1'b1;
            end
            16'h0023: d.kind = KIND_SETPOS;
            default: d.kind = KIND_NONE;
        endcase
        // variant within each group of four: inv/out, inv/in, not/in, not/out
        if (d.kind == KIND_REF) begin
            logic [1:0] v;
            v = 2'(m[1:0] - ((m < 16'h000b) ? 2'd3 :
                             (m < 16'h0017) ? 2'd3 :
                             (m < 16'h001b) ? 2'd3 : 2'd3));
            d.invert  = (v == 2'd0) || (v == 2'd1);
            d.outside = (v == 2'd0) || (v == 2'd3);
        end
        return d;
    endfunction : decode

    // -------------------------------------------------------------------
    // pin synchronisers, a change counts when stages two and three agree
    // -------------------------------------------------------------------
    logic [PIN_COUNT-1:0] pin_raw;
    logic [PIN_COUNT-1:0] pin_s1;
    logic [PIN_COUNT-1:0] pin_s2;
    logic [PIN_COUNT-1:0] pin_s3;
    logic [PIN_COUNT-1:0] pin_ok;
    assign pin_raw = {index_pulse_in, reference_switch_in,
                      positive_limit_switch_in, negative_limit_switch_in};
    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++) begin : g_sync
            always_ff @(posedge clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    pin_s1[gi] <= 1'b0;
                    pin_s2[gi] <= 1'b0;
                    pin_s3[gi] <= 1'b0;
                    pin_ok[gi] <= 1'b0;
                end else begin
                    pin_s1[gi] <= pin_raw[gi];
                    pin_s2[gi] <= pin_s1[gi];
                    pin_s3[gi] <= pin_s2[gi];
                    if (pin_s2[gi] == pin_s3[gi]) begin
                        pin_ok[gi] <= pin_s3[gi];
                    end
                end
            end
        end
    endgenerate

    // -------------------------------------------------------------------
    // parameter registers
    // -------------------------------------------------------------------
    logic [15:0] homing_method_select;
    logic [31:0] position_set_value;
    logic [31:0] switch_point_search_limit;
    logic [31:0] switch_offset_distance;
    logic [31:0] home_position_value;
    logic [31:0] overtravel_search_limit;

    // out-of-range writes are dropped so the stored value stays legal
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            homing_method_select      <= RST_METHOD;
            position_set_value        <= RST_SETPOS;
            switch_point_search_limit <= RST_SP_LIMIT;
            switch_offset_distance    <= RST_OFFSET;
            home_position_value       <= RST_HOME;
            overtravel_search_limit   <= RST_OT_LIMIT;
        end else if (param_wr_in) begin
            case (param_addr_in)
                ADDR_METHOD: begin
                    if (param_wdata_in[15:0] >= METHOD_MIN &&
                        param_wdata_in[15:0] <= METHOD_MAX &&
                        param_wdata_in[31:16] == 16'h0000) begin
                        homing_method_select <= param_wdata_in[15:0];
                    end
                end
                ADDR_SETPOS:  position_set_value <= param_wdata_in;
                ADDR_SP_LIMIT: begin
                    if (!param_wdata_in[31]) begin
                        switch_point_search_limit <= param_wdata_in;
                    end
                end
                ADDR_OFFSET: begin
                    if (!param_wdata_in[31] && param_wdata_in != 32'h0) begin
                        switch_offset_distance <= param_wdata_in;
                    end
                end
                ADDR_HOME:    home_position_value <= param_wdata_in;
                ADDR_OT_LIMIT: begin
                    if (!param_wdata_in[31]) begin
                        overtravel_search_limit <= param_wdata_in;
                    end
                end
                default: ;
            endcase
        end
    end

    // read data, unknown addresses read as zero
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            param_rdata_out <= 32'h0000_0000;
        end else if (param_rd_in) begin
            case (param_addr_in)
                ADDR_METHOD:   param_rdata_out <= {16'h0000,
                                                   homing_method_select};
                ADDR_SETPOS:   param_rdata_out <= position_set_value;
                ADDR_SP_LIMIT: param_rdata_out <= switch_point_search_limit;
                ADDR_OFFSET:   param_rdata_out <= switch_offset_distance;
                ADDR_HOME:     param_rdata_out <= home_position_value;
                ADDR_OT_LIMIT: param_rdata_out <= overtravel_search_limit;
                default:       param_rdata_out <= 32'h0000_0000;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // movement sequencer
    // -------------------------------------------------------------------
    method_info_t info;
    home_state_t  state;
    logic         start_d;
    logic         index_d;
    logic         seen_active;
    logic         homed;
    logic [31:0]  mark_pos;
    logic [31:0]  lat_offset;
    logic [31:0]  lat_home;
    logic [31:0]  lat_sp_limit;
    logic [31:0]  lat_ot_limit;
    logic [31:0]  diff;
    logic [31:0]  travel;
    logic         sw;
    logic         back_pos;
    logic         final_pos;
    logic         start_rise;
    logic         index_rise;

    // method read live so a new value acts at once
    assign info       = decode(homing_method_select);
    assign sw         = (info.kind == KIND_LIMIT) ?
                        (info.search_pos ? pin_ok[1] : pin_ok[0]) : pin_ok[2];
    assign back_pos   = (info.kind == KIND_REF && !info.invert) ?
                        info.search_pos : !info.search_pos;
    assign final_pos  = (info.kind == KIND_INDEX) ? info.search_pos :
                        (info.outside ? back_pos : !back_pos);
    assign diff       = position_in - mark_pos;
    assign travel     = diff[31] ? 32'(-diff) : diff;
    assign start_rise = homing_start_in && !start_d;
    assign index_rise = pin_ok[3] && !index_d;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            start_d <= 1'b0;
            index_d <= 1'b0;
        end else begin
            start_d <= homing_start_in;
            index_d <= pin_ok[3];
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state        <= ST_IDLE;
            seen_active  <= 1'b0;
            homed        <= 1'b0;
            homing_error_out <= 1'b0;
            mark_pos     <= 32'h0000_0000;
            lat_offset   <= RST_OFFSET;
            lat_home     <= RST_HOME;
            lat_sp_limit <= RST_SP_LIMIT;
            lat_ot_limit <= RST_OT_LIMIT;
            pos_load_out <= 1'b0;
            pos_load_value_out <= 32'h0000_0000;
        end else begin
            pos_load_out <= 1'b0;
            if (halt_in && (state == ST_SEARCH || state == ST_HALT1 ||
                            state == ST_BACK || state == ST_FINAL ||
                            state == ST_HALT2)) begin
                state <= ST_ABORT;
                homed <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        if (start_rise && !homing_error_out) begin
                            lat_offset   <= switch_offset_distance;
                            lat_home     <= home_position_value;
                            lat_sp_limit <= switch_point_search_limit;
                            lat_ot_limit <= overtravel_search_limit;
                            case (info.kind)
                                KIND_LIMIT, KIND_REF: begin
                                    homed <= 1'b0;
                                    state <= ST_SEARCH;
                                end
                                KIND_INDEX: begin
                                    homed <= 1'b0;
                                    state <= ST_FINAL;
                                end
                                KIND_SETPOS: begin
                                    // only allowed at standstill
                                    if (motor_standstill_in) begin
                                        pos_load_out       <= 1'b1;
                                        pos_load_value_out <=
                                            position_set_value;
                                        homed              <= 1'b1;
                                    end
                                end
                                default: begin
                                    homed            <= 1'b0;
                                    homing_error_out <= 1'b1;
                                    state            <= ST_FAULT;
                                end
                            endcase
                        end
                    end
                    ST_SEARCH: begin
                        if (sw) begin
                            state <= ST_HALT1;
                        end
                    end
                    ST_HALT1: begin
                        if (motor_standstill_in) begin
                            seen_active <= sw;
                            mark_pos    <= position_in;
                            state       <= ST_BACK;
                        end
                    end
                    ST_BACK: begin
                        if (!seen_active) begin
                            if (sw) begin
                                seen_active <= 1'b1;
                                mark_pos    <= position_in;
                            end else if (lat_ot_limit != 32'h0 &&
                                         travel > lat_ot_limit) begin
                                homing_error_out <= 1'b1;
                                state            <= ST_FAULT;
                            end
                        end else if (!sw) begin
                            mark_pos <= position_in;
                            state    <= ST_FINAL;
                        end else if (lat_sp_limit != 32'h0 &&
                                     travel > lat_sp_limit) begin
                            homing_error_out <= 1'b1;
                            state            <= ST_FAULT;
                        end
                    end
                    ST_FINAL: begin
                        if (info.use_index ? index_rise
                                           : travel >= lat_offset) begin
                            mark_pos <= position_in;
                            state    <= ST_HALT2;
                        end
                    end
                    ST_HALT2: begin
                        // the stop overshoots the reference point, so the
                        // loaded value carries the overshoot
                        if (motor_standstill_in) begin
                            pos_load_out       <= 1'b1;
                            pos_load_value_out <= 32'(lat_home + diff);
                            homed              <= 1'b1;
                            state              <= ST_IDLE;
                        end
                    end
                    ST_ABORT: begin
                        if (motor_standstill_in) begin
                            state <= ST_IDLE;
                        end
                    end
                    ST_FAULT: begin
                        homed <= 1'b0;
                        if (error_ack_in && motor_standstill_in) begin
                            homing_error_out <= 1'b0;
                            state            <= ST_IDLE;
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    // -------------------------------------------------------------------
    // motion command and status
    // -------------------------------------------------------------------
    // stop in halt, fault and abort states, direction per phase
    assign move_run_out      = (state == ST_SEARCH) || (state == ST_BACK) ||
                               (state == ST_FINAL);
    assign move_positive_out = (state == ST_SEARCH) ? info.search_pos :
                               (state == ST_BACK) ? back_pos : final_pos;
    assign move_slow_out     = (state != ST_SEARCH);

    always_comb begin
        drive_status_word_out = 16'h0000;
        drive_status_word_out[STAT_HOMED_BIT] = homed;
        drive_status_word_out[STAT_ERROR_BIT] = homing_error_out;
    end

endmodule : homing_method_control

// file: tb/homing_asserts.sv
`timescale 1ns/10ps
module homing_asserts (
    input wire logic        clk_in,
    input wire logic        nrst_in,
    input wire logic        halt_in,
    input wire logic        error_ack_in,
    input wire logic        move_run_out,
    input wire logic        pos_load_out,
    input wire logic        homing_error_out,
    input wire logic [15:0] drive_status_word_out
);
    // one clock domain, so clock and reset are set once
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);
    a_load_one_cycle:
    assert property (pos_load_out |=> !pos_load_out)
        else $error("load pulse longer than one cycle");
    a_homed_on_load:
    assert property (pos_load_out |-> ##[0:1] drive_status_word_out[12])
        else $error("homed bit missing after load");
    a_error_stops:
    assert property (homing_error_out |-> !move_run_out)
        else $error("motor runs while error is set");
    a_error_unhomed:
    assert property (homing_error_out |-> !drive_status_word_out[12])
        else $error("homed bit set with error");
    a_error_held:
    assert property (homing_error_out && !error_ack_in |=> homing_error_out)
        else $error("error dropped without acknowledge");
    a_error_status:
    assert property (drive_status_word_out[13] == homing_error_out)
        else $error("status error bit differs from error");
    a_halt_stops:
    assert property (halt_in ##1 halt_in |-> !move_run_out)
        else $error("motor still runs under halt");
    a_halt_unhomed:
    assert property (halt_in && move_run_out |=> !drive_status_word_out[12])
        else $error("interrupted run left homed bit set");
    c_load: cover property (pos_load_out);
    c_error: cover property ($rose(homing_error_out));
    c_halt: cover property (halt_in && move_run_out);
endmodule : homing_asserts

bind homing_method_control homing_asserts i_asserts (
    .clk_in               (clk_in),
    .nrst_in              (nrst_in),
    .halt_in              (halt_in),
    .error_ack_in         (error_ack_in),
    .move_run_out         (move_run_out),
    .pos_load_out         (pos_load_out),
    .homing_error_out     (homing_error_out),
    .drive_status_word_out(drive_status_word_out)
);

// file: tb/fieldbus_master.sv
`timescale 1ns/10ps
module fieldbus_master (
    input  wire logic        clk_in,
    input  wire logic [31:0] param_rdata_in,
    output logic      [15:0] param_addr_out,
    output logic      [31:0] param_wdata_out,
    output logic             param_wr_out,
    output logic             param_rd_out
);
    // idle bus at time zero
    initial begin
        param_addr_out  = 16'h0000;
        param_wdata_out = 32'h0000_0000;
        param_wr_out    = 1'b0;
        param_rd_out    = 1'b0;
    end
    // idle lines show inverted data, so a stale word never passes
    task automatic put(input logic [15:0] a, input logic [31:0] d);
        param_addr_out  = a;
        param_wdata_out = d;
        param_wr_out    = 1'b1;
        @(posedge clk_in);
        #1;
        param_wr_out    = 1'b0;
        param_addr_out  = ~a;
        param_wdata_out = ~d;
        @(posedge clk_in);
        #1;
    endtask : put
    // read data is registered at the strobe edge
    task automatic get(input logic [15:0] a, output logic [31:0] v);
        param_addr_out = a;
        param_rd_out   = 1'b1;
        @(posedge clk_in);
        #1;
        param_rd_out   = 1'b0;
        param_addr_out = ~a;
        v              = param_rdata_in;
        @(posedge clk_in);
        #1;
    endtask : get
endmodule : fieldbus_master

// file: tb/tb.sv
`timescale 1ns/10ps
module tb;
    import homing_pkg::*;
    logic        clk_in = 1'b0;
    logic        nrst_in = 1'b0;
    logic [15:0] addr;
    logic [31:0] wdata, rdata, lval, pos = 32'h0000_0000;
    logic        wr, rd, run, dirp, slow, load, err, stuck = 1'b0;
    logic        start = 1'b0, halt = 1'b0, ack = 1'b0, still = 1'b1;
    logic        zero = 1'b0;
    logic [15:0] status;
    int          fails = 0, comparisons = 0, cycles = 0;
    // 10 MHz clock
    always #50 clk_in = ~clk_in;
    // axis: one unit a cycle while commanded, still a cycle after;
    // zeroing goes through here so the position has a single driver
    always @(posedge clk_in) begin
        if (zero) pos <= 32'h0000_0000;
        else if (run) pos <= dirp ? pos + 32'h0000_0001
                                  : pos - 32'h0000_0001;
        still <= !run;
        cycles++;
        if (cycles == 20000) begin
            fails++;
            print_verdict();
        end
    end
    homing_method_control i_dut (.clk_in(clk_in), .nrst_in(nrst_in),
        .param_addr_in(addr), .param_wdata_in(wdata), .param_wr_in(wr),
        .param_rd_in(rd), .param_rdata_out(rdata),
        .homing_start_in(start), .halt_in(halt), .error_ack_in(ack),
        .negative_limit_switch_in($signed(pos) <= -40),
        .positive_limit_switch_in(stuck || $signed(pos) >= 40),
        .reference_switch_in($signed(pos) >= 100),
        .index_pulse_in(pos[3:0] == 4'h0), .position_in(pos),
        .motor_standstill_in(still), .move_run_out(run),
        .move_positive_out(dirp), .move_slow_out(slow),
        .pos_load_out(load), .pos_load_value_out(lval),
        .homing_error_out(err), .drive_status_word_out(status));
    fieldbus_master i_master (.clk_in(clk_in), .param_rdata_in(rdata),
        .param_addr_out(addr), .param_wdata_out(wdata),
        .param_wr_out(wr), .param_rd_out(rd));
    task automatic print_verdict();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            fails++;
            $display("wrong value at %0t: %h not %h", $time, seen, want);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick
    // bounded wait for the axis to stop
    task automatic wait_still();
        for (int i = 0; i < 300 && !(still && !run); i++) tick(1);
    endtask : wait_still
    task automatic regs_and_range();
        logic [15:0] a [4] = '{ADDR_SP_LIMIT, ADDR_HOME, ADDR_OT_LIMIT, 0};
        int          m [4] = '{0, 36, 1, 35};
        int          e [4] = '{18, 18, 1, 35};
        logic [31:0] v;
        i_master.get(ADDR_METHOD, v);
        check(v, 32'h0000_0012);
        i_master.get(ADDR_OFFSET, v);
        check(v, 32'h0000_0018);
        foreach (a[k]) begin
            i_master.get(a[k], v);
            check(v, 32'h0000_0000);
        end
        foreach (m[k]) begin
            i_master.put(ADDR_METHOD, m[k]);
            i_master.get(ADDR_METHOD, v);
            check(v, e[k]);
        end
        i_master.put(ADDR_OFFSET, 32'h0000_0000);
        i_master.get(ADDR_OFFSET, v);
        check(v, 32'h0000_0018);
    endtask : regs_and_range
    // every search code except 7 starts toward its documented side
    task automatic method_dirs();
        int          c [21] = '{1, 2, 8, 9, 10, 11, 12, 13, 14, 17, 18,
                                23, 24, 25, 26, 27, 28, 29, 30, 31, 34};
        logic [35:0] up = 36'h4_0784_0704;
        foreach (c[k]) begin
            i_master.put(ADDR_METHOD, c[k]);
            start = 1'b1;
            tick(2);
            check(run, 1'b1);
            check(dirp, up[c[k]]);
            halt = 1'b1;
            tick(2);
            check(run, 1'b0);
            wait_still();
            start = 1'b0;
            halt  = 1'b0;
            tick(2);
            check(status[12], 1'b0);
        end
    endtask : method_dirs
    task automatic set_position();
        i_master.put(ADDR_SETPOS, 32'h1234_5678);
        i_master.put(ADDR_METHOD, 32'h0000_0023);
        start = 1'b1;
        for (int i = 0; i < 10 && !load; i++) tick(1);
        tick(1);
        check(lval, 32'h1234_5678);
        check(status[12], 1'b1);
        start = 1'b0;
        tick(1);
    endtask : set_position
    // full run of code 18 with a home value in the middle of a nibble
    task automatic limit_run();
        logic back = 1'b0;
        zero = 1'b1;
        tick(1);
        zero = 1'b0;
        i_master.put(ADDR_HOME, 32'h0000_1008);
        i_master.put(ADDR_METHOD, 32'h0000_0012);
        start = 1'b1;
        tick(2);
        check({run, dirp, slow}, 3'b110);
        check(status[12], 1'b0);
        for (int i = 0; i < 600 && !load; i++) begin
            back = back | (run & !dirp & slow);
            tick(1);
        end
        tick(1);
        check(back, 1'b1);
        check(lval[31:4], 28'h000_0100);
        check(status[12], 1'b1);
        start = 1'b0;
        tick(1);
    endtask : limit_run
    // switch stuck on, so the switching point never comes
    task automatic search_limit();
        zero  = 1'b1;
        tick(1);
        zero  = 1'b0;
        stuck = 1'b1;
        i_master.put(ADDR_SP_LIMIT, 32'h0000_000a);
        start = 1'b1;
        for (int i = 0; i < 300 && !err; i++) tick(1);
        check({err, status[13:12], run}, 4'b1100);
        ack = 1'b1;
        wait_still();
        tick(2);
        check(err, 1'b0);
        {ack, start, stuck} = 3'b000;
        tick(1);
        // code 3 is in range but names no method, so a start is an error
        i_master.put(ADDR_METHOD, 32'h0000_0003);
        start = 1'b1;
        tick(2);
        check(err, 1'b1);
    endtask : search_limit
    initial begin
        tick(2);
        nrst_in = 1'b1;
        tick(1);
        regs_and_range();
        method_dirs();
        set_position();
        limit_run();
        search_limit();
        print_verdict();
    end
endmodule : tb
